// file: include/uts_pkg.sv
package uts_pkg;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int FLAG_N = 4;
  // Flag vector positions
  localparam int FLG_RXFULL = 0;
  localparam int FLG_PERR = 1;
  localparam int FLG_FERR = 2;
  localparam int FLG_OVR = 3;
  // Bit-clock counts at which the receiver samples
  localparam logic [4:0] RT_SAMPLE_FIRST = 5'h08;
  localparam logic [4:0] RT_SAMPLE_MID = 5'h07;
  localparam logic [4:0] RT_SAMPLE_LAST = 5'h06;
  localparam logic [4:0] RT_LEN_15 = 5'h0f;
  localparam logic [4:0] RT_LEN_16 = 5'h10;
  localparam logic [4:0] RT_LEN_17 = 5'h11;
  localparam logic [2:0] BCS_16 = 3'h0;
  localparam logic [2:0] BCS_16_17 = 3'h1;
  localparam logic [2:0] BCS_15 = 3'h2;
  localparam logic [2:0] BCS_15_16 = 3'h3;
  localparam logic [2:0] BCS_17 = 3'h4;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam logic [FLAG_N-1:0] FLAGS_RESET = 4'h0;

  typedef struct packed {
    logic tx_enable;
    logic receive_enable_bit;
    logic parity_enable;
    logic parity_odd;
    logic stop_bit_count_sel;
    logic infrared_mode_sel;
    logic baud_clock_source_sel;
    logic [2:0] per_bit_clock_count_sel;
    logic [7:0] baud_divisor_reg;
  } uts_cfg_t;

  typedef struct packed {
    logic low_power_stop_mode;
    logic low_power_idle_mode;
    logic low_power_sleep_mode;
  } uts_pwr_t;

  typedef struct packed {
    logic tx_busy;
    logic tx_buffer_full_flag;
    logic overrun_flag;
    logic framing_err;
    logic parity_err;
    logic rx_buffer_full_flag;
  } uts_status_t;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_START = 5'b00010,
    PH_DATA = 5'b00100,
    PH_PARITY = 5'b01000,
    PH_STOP = 5'b10000
  } uts_phase_t;
endpackage

// file: rtl/uts_fifo.sv
`timescale 1ns/100ps
module uts_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic in_valid, // Fill side offers a word
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word to store
  output logic out_valid, // A word is waiting
  input wire logic out_ready, // Drain side takes the word
  output logic [W-1:0] out_data // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: rtl/uts_core.sv
`timescale 1ns/100ps
// Functional notes
// R1: Software enables transmit, checks full flag first.
// R2: Buffer write sets full flag, then shifts out.
// R3: Frame: start, data, optional parity, stop bits.
// R4: Bit rate from source, bit-clock count, divisor.
// R5: Transmit start clears full flag, pulses interrupt.
// R6: Rewrite before transfer replaces older byte.
// R7: Output static when disabled, unwritten, low power.
// R8: Stop received: load data, set full, interrupt.
// R9: Unread buffer: set overrun, interrupt, keep old.
// R10: Overrun already set: discard silently, no interrupt.
// R11: Discarded frames never set parity or framing.
// R12: Parity mismatch sets parity flag, interrupt.
// R13: Zero stop bit sets framing flag, interrupt.
// R14: Status read then buffer read clears flag.
// R15: Flag set after status read survives buffer read.
// R16: Buffer read clearing parity error: data undefined.
// R17: Receive full flag clears by same sequence.
// R18: Bit decided by majority at counts 8,7,6.
// R19: Each interrupt is one system-clock pulse.
// R20: Per-flag armed bit gates the clearing read.
module uts_core (
  input wire logic sys_clk, // System clock, 10 MHz
  input wire logic resetn, // Async reset, active low
  input wire uts_pkg::uts_cfg_t cfg, // Control settings
  input wire uts_pkg::uts_pwr_t pwr, // Low-power mode levels
  input wire logic baud_ext_tick, // Alternate base clock enable
  input wire logic tx_write, // Write strobe of transmit_buffer
  input wire logic [7:0] tx_wdata, // Byte for transmit_buffer
  input wire logic tx_in_valid, // Stream byte offered
  output logic tx_in_ready, // Stream queue has room
  input wire logic [7:0] tx_in_data, // Stream byte
  input wire logic status_read, // Read strobe of serial_status_reg
  output uts_pkg::uts_status_t status_data, // Status captured on read
  output uts_pkg::uts_status_t status_live, // Current flags
  input wire logic rx_read, // Read strobe of receive_buffer
  output logic [7:0] receive_buffer, // Received byte
  input wire logic serial_in_pin, // Serial input pin
  output logic serial_out_pin, // Serial output pin
  output logic transmit_irq, // Transmit interrupt pulse
  output logic receive_irq // Receive interrupt pulse
);
  import uts_pkg::*;

  function automatic logic [4:0] bit_len(input logic [2:0] sel, input logic alt);
    logic [4:0] len;
    len = RT_LEN_16;
    case (sel)
      BCS_16: len = RT_LEN_16;
      BCS_16_17: len = alt ? RT_LEN_17 : RT_LEN_16;
      BCS_15: len = RT_LEN_15;
      BCS_15_16: len = alt ? RT_LEN_16 : RT_LEN_15;
      BCS_17: len = RT_LEN_17;
      default: len = RT_LEN_16;
    endcase
    return len - 5'h01;
  endfunction

  // Bit-clock enable
  logic [7:0] div_cnt;
  logic rt_tick;
  logic src_tick;
  assign src_tick = cfg.baud_clock_source_sel ? baud_ext_tick : 1'b1; // R4
  assign rt_tick = src_tick && (div_cnt == 8'h00);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 8'h00;
    end else if (src_tick) begin
      div_cnt <= (div_cnt == 8'h00) ? cfg.baud_divisor_reg : div_cnt - 8'h01; // R4
    end
  end

  // Transmit buffer and stream queue
  logic tx_full;
  logic [7:0] tx_hold;
  logic q_valid;
  logic q_ready;
  logic [7:0] q_data;
  logic tx_start;
  logic low_power;
  logic tx_written;
  assign low_power = pwr.low_power_stop_mode | pwr.low_power_idle_mode
                     | pwr.low_power_sleep_mode;
  assign q_ready = !tx_full && !tx_write;

  uts_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) uts_fifo_i (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_full <= 1'b0;
      tx_hold <= BUF_RESET;
    end else if (tx_write) begin
      tx_full <= 1'b1; // R2
      tx_hold <= tx_wdata; // R6
    end else if (q_valid && q_ready) begin
      tx_full <= 1'b1;
      tx_hold <= q_data;
    end else if (tx_start) begin
      tx_full <= 1'b0; // R5
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_written <= 1'b0;
    end else if (!cfg.tx_enable) begin
      tx_written <= 1'b0;
    end else if (tx_full) begin
      tx_written <= 1'b1;
    end
  end

  // Transmit shifter
  uts_phase_t tx_ph;
  logic [4:0] tx_cnt;
  logic tx_alt;
  logic [2:0] tx_idx;
  logic [7:0] tx_shift;
  logic tx_par;
  logic tx_stop2;
  logic tx_bit;
  assign tx_start = rt_tick && (tx_ph == PH_IDLE) && tx_full && cfg.tx_enable && !low_power;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ph <= PH_IDLE;
      tx_cnt <= 5'h00;
      tx_alt <= 1'b0;
      tx_idx <= 3'h0;
      tx_shift <= BUF_RESET;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
    end else if (!cfg.tx_enable || low_power) begin
      tx_ph <= PH_IDLE;
    end else if (tx_start) begin
      tx_ph <= PH_START; // R3
      tx_shift <= tx_hold;
      tx_par <= (^tx_hold) ^ cfg.parity_odd;
      tx_cnt <= bit_len(cfg.per_bit_clock_count_sel, 1'b0);
      tx_alt <= 1'b1;
      tx_idx <= 3'h0;
      tx_stop2 <= 1'b0;
    end else if (rt_tick && tx_ph != PH_IDLE) begin
      if (tx_cnt != 5'h00) begin
        tx_cnt <= tx_cnt - 5'h01;
      end else begin
        tx_cnt <= bit_len(cfg.per_bit_clock_count_sel, tx_alt);
        tx_alt <= !tx_alt;
        case (tx_ph)
          PH_START: begin
            tx_ph <= PH_DATA;
          end
          PH_DATA: begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == LAST_DATA_BIT) begin
              tx_ph <= cfg.parity_enable ? PH_PARITY : PH_STOP; // R3
            end
          end
          PH_PARITY: begin
            tx_ph <= PH_STOP;
          end
          PH_STOP: begin
            if (cfg.stop_bit_count_sel && !tx_stop2) begin
              tx_stop2 <= 1'b1; // R3
            end else begin
              tx_ph <= PH_IDLE;
            end
          end
          default: begin
            tx_ph <= PH_IDLE;
          end
        endcase
      end
    end
  end

  always_comb begin
    case (tx_ph)
      PH_START: tx_bit = 1'b0;
      PH_DATA: tx_bit = tx_shift[0];
      PH_PARITY: tx_bit = tx_par;
      default: tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_pin <= 1'b1;
    end else if (!cfg.tx_enable || !tx_written || low_power) begin
      serial_out_pin <= !cfg.infrared_mode_sel; // R7
    end else begin
      serial_out_pin <= cfg.infrared_mode_sel ? !tx_bit : tx_bit;
    end
  end

  // Receive input synchroniser
  logic rx_s1;
  logic rx_s2;
  logic rx_prev;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end

  // Receive shifter
  uts_phase_t rx_ph;
  logic [4:0] rx_cnt;
  logic rx_alt;
  logic [2:0] rx_idx;
  logic [7:0] rx_shift;
  logic [1:0] votes;
  logic rx_bit;
  logic rx_dec;
  logic rx_par_bad;
  logic rx_stop_bad;
  logic rx_stop2;
  logic rx_done;
  assign rx_bit = (votes[1] & votes[0]) | (votes[1] & rx_s2) | (votes[0] & rx_s2); // R18
  assign rx_dec = rt_tick && (rx_ph != PH_IDLE) && (rx_cnt == RT_SAMPLE_LAST);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      votes <= 2'b00;
    end else if (rt_tick && rx_cnt == RT_SAMPLE_FIRST) begin
      votes[1] <= rx_s2; // R18
    end else if (rt_tick && rx_cnt == RT_SAMPLE_MID) begin
      votes[0] <= rx_s2; // R18
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ph <= PH_IDLE;
      rx_cnt <= 5'h00;
      rx_alt <= 1'b0;
      rx_idx <= 3'h0;
      rx_shift <= BUF_RESET;
      rx_par_bad <= 1'b0;
      rx_stop_bad <= 1'b0;
      rx_stop2 <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!cfg.receive_enable_bit) begin
        rx_ph <= PH_IDLE;
      end else if (rx_ph == PH_IDLE) begin
        if (rx_prev && !rx_s2) begin
          rx_ph <= PH_START;
          rx_cnt <= bit_len(cfg.per_bit_clock_count_sel, 1'b0);
          rx_alt <= 1'b1;
          rx_idx <= 3'h0;
          rx_stop_bad <= 1'b0;
          rx_stop2 <= 1'b0;
        end
      end else if (rx_dec && rx_ph == PH_START && rx_bit) begin
        rx_ph <= PH_IDLE;
      end else if (rx_dec && rx_ph == PH_STOP) begin
        if (cfg.stop_bit_count_sel && !rx_stop2) begin
          rx_stop2 <= 1'b1;
          rx_stop_bad <= !rx_bit;
          rx_cnt <= rx_cnt - 5'h01;
        end else begin
          rx_stop_bad <= rx_stop_bad | !rx_bit; // R13
          rx_done <= 1'b1; // R8
          rx_ph <= PH_IDLE;
        end
      end else if (rt_tick) begin
        if (rx_dec && rx_ph == PH_DATA) begin
          rx_shift <= {rx_bit, rx_shift[7:1]};
        end
        if (rx_dec && rx_ph == PH_PARITY) begin
          rx_par_bad <= (^rx_shift) ^ cfg.parity_odd ^ rx_bit; // R12
        end
        if (rx_cnt != 5'h00) begin
          rx_cnt <= rx_cnt - 5'h01;
        end else begin
          rx_cnt <= bit_len(cfg.per_bit_clock_count_sel, rx_alt);
          rx_alt <= !rx_alt;
          case (rx_ph)
            PH_START: begin
              rx_ph <= PH_DATA;
              rx_par_bad <= 1'b0;
            end
            PH_DATA: begin
              rx_idx <= rx_idx + 3'h1;
              if (rx_idx == LAST_DATA_BIT) begin
                rx_ph <= cfg.parity_enable ? PH_PARITY : PH_STOP;
              end
            end
            PH_PARITY: begin
              rx_ph <= PH_STOP;
            end
            PH_STOP: begin
              rx_ph <= PH_STOP; // R3
            end
            default: begin
              rx_ph <= PH_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Receive buffer and sticky flags
  logic [FLAG_N-1:0] flags;
  logic [FLAG_N-1:0] armed;
  logic [FLAG_N-1:0] flag_set;
  logic rx_load;
  logic rx_ovr;
  logic stop_now_bad;
  assign stop_now_bad = rx_stop_bad;
  assign rx_load = rx_done && !flags[FLG_RXFULL] && !flags[FLG_OVR]; // R10
  assign rx_ovr = rx_done && flags[FLG_RXFULL] && !flags[FLG_OVR]; // R9
  always_comb begin
    flag_set = '0;
    flag_set[FLG_RXFULL] = rx_load; // R8
    flag_set[FLG_PERR] = rx_load && cfg.parity_enable && rx_par_bad; // R11
    flag_set[FLG_FERR] = rx_load && stop_now_bad; // R11
    flag_set[FLG_OVR] = rx_ovr; // R9
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      receive_buffer <= BUF_RESET;
    end else if (rx_load) begin
      receive_buffer <= rx_shift; // R9 R16
    end
  end

  for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        flags[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flags[i] <= 1'b1;
      end else if (rx_read && armed[i]) begin
        flags[i] <= 1'b0; // R14 R17
      end
    end
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        armed[i] <= 1'b0;
      end else if (status_read) begin
        armed[i] <= flags[i]; // R20
      end else if (rx_read) begin
        armed[i] <= 1'b0; // R15
      end
    end
  end

  always_comb begin
    status_live.tx_busy = (tx_ph != PH_IDLE) || tx_full;
    status_live.tx_buffer_full_flag = tx_full;
    status_live.overrun_flag = flags[FLG_OVR];
    status_live.framing_err = flags[FLG_FERR];
    status_live.parity_err = flags[FLG_PERR];
    status_live.rx_buffer_full_flag = flags[FLG_RXFULL];
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_data <= '0;
    end else if (status_read) begin
      status_data <= status_live;
    end
  end

  // Interrupt pulses
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      transmit_irq <= 1'b0;
      receive_irq <= 1'b0;
    end else begin
      transmit_irq <= tx_start; // R5
      receive_irq <= rx_load || rx_ovr; // R19
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_tx_irq_pulse: assert property (transmit_irq |=> !transmit_irq) // R19
    else $error("transmit interrupt longer than one cycle");
  a_tx_start_clear: assert property (tx_start && !tx_write && !q_valid // R5
    |=> !tx_full && transmit_irq)
    else $error("transmit start did not clear full flag");
  a_tx_write_full: assert property (tx_write |=> tx_full && tx_hold == $past(tx_wdata)) // R2
    else $error("transmit write not captured");
  a_out_static: assert property (!cfg.tx_enable // R7
    |=> serial_out_pin == !$past(cfg.infrared_mode_sel))
    else $error("serial output not static while disabled");
  a_ovr_keep_buf: assert property (rx_done && flags[FLG_RXFULL] |=> $stable(receive_buffer)) // R9
    else $error("receive buffer overwritten on overrun");
  a_ovr_silent: assert property (rx_done && flags[FLG_OVR] |=> !receive_irq) // R10
    else $error("interrupt raised while overrun pending");
  a_ovr_no_err: assert property (rx_done && flags[FLG_RXFULL] && !flags[FLG_PERR] // R11
    |=> !flags[FLG_PERR])
    else $error("parity flag set by discarded frame");
  a_rx_load_full: assert property (rx_load // R8
    |=> flags[FLG_RXFULL] && receive_irq ##1 !receive_irq)
    else $error("received byte did not set full flag");
  a_frame_err: assert property (rx_load && rx_stop_bad |=> flags[FLG_FERR]) // R13
    else $error("bad stop bit did not set framing flag");
  a_clear_armed: assert property (rx_read && armed[FLG_RXFULL] && !flag_set[FLG_RXFULL] // R17
    |=> !flags[FLG_RXFULL])
    else $error("armed full flag not cleared");
  a_keep_unarmed: assert property (rx_read && !status_read && !armed[FLG_PERR] // R15
    && flags[FLG_PERR] |=> flags[FLG_PERR])
    else $error("unarmed parity flag cleared");

  c_tx_start: cover property (tx_start ##[1:300] tx_ph == PH_STOP);
  c_rx_load: cover property (rx_load);
  c_overrun: cover property (rx_ovr);
  c_parity: cover property (flag_set[FLG_PERR]);
endmodule

// file: bench/uts_serial_peer.sv
`timescale 1ns/100ps
module uts_serial_peer (
  input wire logic sys_clk, // System clock
  input wire logic line_from_dut, // Device serial output
  output logic line_to_dut, // Device serial input
  input wire logic par_en, // Parity bit present
  input wire logic par_odd, // Odd parity
  input wire logic two_stops, // Two stop bits
  input wire logic [31:0] bit_len // Bit time in sys_clk cycles
);
  logic [9:0] rx_q[$]; // {parity ok, stops ok, data}
  logic [7:0] d;
  logic p_ok;
  logic s_ok;

  initial line_to_dut = 1'b1;

  task automatic drive_bit(input logic v);
    @(negedge sys_clk);
    line_to_dut = v;
    repeat (bit_len - 1) @(negedge sys_clk);
  endtask

  // One frame, with a wrong parity or stop bit on request
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    drive_bit(1'b0);
    for (int i = 0; i < 8; i++) drive_bit(b[i]);
    if (par_en) drive_bit(^b ^ par_odd ^ bad_par);
    drive_bit(~bad_stop);
    if (two_stops) drive_bit(1'b1);
    drive_bit(1'b1);
  endtask

  // Decodes frames from the device, sampling mid-bit
  always begin
    @(negedge line_from_dut);
    repeat (bit_len / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_len) @(posedge sys_clk);
      d[i] = line_from_dut;
    end
    p_ok = 1'b1;
    if (par_en) begin
      repeat (bit_len) @(posedge sys_clk);
      p_ok = (line_from_dut === (^d ^ par_odd));
    end
    s_ok = 1'b1;
    repeat (two_stops ? 2 : 1) begin
      repeat (bit_len) @(posedge sys_clk);
      s_ok = s_ok & (line_from_dut === 1'b1);
    end
    rx_q.push_back({p_ok, s_ok, d});
  end
endmodule

// file: bench/uart_txrx_status_flags_tb_top.sv
`timescale 1ns/100ps
module uart_txrx_status_flags_tb_top;
  import uts_pkg::*;
  logic sys_clk, resetn, baud_ext_tick, tx_write, tx_in_valid, tx_in_ready;
  logic status_read, rx_read, serial_in_pin, serial_out_pin, transmit_irq, receive_irq;
  logic [7:0] tx_wdata, tx_in_data, receive_buffer;
  uts_cfg_t cfg;
  uts_pwr_t pwr;
  uts_status_t status_data, status_live;
  int bit_len, err_count, comparisons, cycles, rx_irqs;

  uts_core uts_core_i (.sys_clk(sys_clk), .resetn(resetn), .cfg(cfg), .pwr(pwr),
    .baud_ext_tick(baud_ext_tick), .tx_write(tx_write), .tx_wdata(tx_wdata),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
    .status_read(status_read), .status_data(status_data), .status_live(status_live),
    .rx_read(rx_read), .receive_buffer(receive_buffer), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .transmit_irq(transmit_irq), .receive_irq(receive_irq));

  uts_serial_peer uts_serial_peer_i (.sys_clk(sys_clk), .line_from_dut(serial_out_pin),
    .line_to_dut(serial_in_pin), .par_en(cfg.parity_enable), .par_odd(cfg.parity_odd),
    .two_stops(cfg.stop_bit_count_sel), .bit_len(bit_len));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Alternate base enable: every other cycle
  always @(negedge sys_clk) baud_ext_tick <= ~baud_ext_tick;

  always @(posedge sys_clk) begin
    cycles++;
    if (receive_irq === 1'b1) rx_irqs++;
    if (cycles == 40000) begin
      err_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk_val(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_val(what, {9'h0, exp}, {9'h0, got});
  endtask

  task automatic tx_wr(input logic [7:0] b);
    @(negedge sys_clk);
    tx_write = 1'b1;
    tx_wdata = b;
    @(negedge sys_clk);
    tx_write = 1'b0;
  endtask

  task automatic pulse_status();
    @(negedge sys_clk);
    status_read = 1'b1;
    @(negedge sys_clk);
    status_read = 1'b0;
  endtask

  task automatic rx_rd(output logic [7:0] v);
    @(negedge sys_clk);
    rx_read = 1'b1;
    v = receive_buffer;
    @(negedge sys_clk);
    rx_read = 1'b0;
  endtask

  task automatic wait_tx_irq(output logic got);
    got = 1'b0;
    for (int n = 0; n < 200 && !got; n++) begin
      @(negedge sys_clk);
      got = (transmit_irq === 1'b1);
    end
  endtask

  task automatic expect_frame(input logic [7:0] b);
    for (int n = 0; n < 20 * bit_len && uts_serial_peer_i.rx_q.size() == 0; n++)
      @(negedge sys_clk);
    if (uts_serial_peer_i.rx_q.size() == 0) chk_val("frame", {2'b11, b}, 10'bx);
    else chk_val("frame", {2'b11, b}, uts_serial_peer_i.rx_q.pop_front());
    repeat (2 * bit_len) @(negedge sys_clk);
  endtask

  task automatic rx_frame(input logic [7:0] b, input logic bp, input logic bs, input int irqs);
    rx_irqs = 0;
    uts_serial_peer_i.send(b, bp, bs);
    chk_val("rx_irq", 10'(irqs), 10'(rx_irqs));
  endtask

  initial begin
    int lens[7] = '{16, 15, 17, 64, 32, 17, 16};
    logic [2:0] sels[7] = '{BCS_16, BCS_15, BCS_17, BCS_16, BCS_16, BCS_16_17, BCS_15_16};
    logic [7:0] v;
    logic got;
    int n;
    cfg = '0;
    pwr = '0;
    resetn = 1'b0;
    {baud_ext_tick, tx_write, tx_in_valid, status_read, rx_read} = 5'h00;
    tx_wdata = 8'h00;
    tx_in_data = 8'h00;
    bit_len = 16;
    repeat (10) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk_val("status", 10'h0, {4'h0, status_live});
    chk_bit("idle_pin", 1'b1, serial_out_pin);
    chk_bit("fifo_ready", 1'b1, tx_in_ready);
    cfg.infrared_mode_sel = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk_bit("ir_idle", 1'b0, serial_out_pin);
    cfg.infrared_mode_sel = 1'b0;
    cfg.tx_enable = 1'b1;
    cfg.receive_enable_bit = 1'b1;
    repeat (300) @(negedge sys_clk);
    chk_bit("enabled_idle", 1'b1, serial_out_pin);
    uts_serial_peer_i.rx_q.delete();
    $display("test idle levels done");
    for (int i = 0; i < 7; i++) begin
      cfg.per_bit_clock_count_sel = sels[i];
      cfg.baud_divisor_reg = (i == 3) ? 8'h03 : 8'h00;
      cfg.baud_clock_source_sel = (i == 4);
      cfg.parity_enable = i[0];
      cfg.parity_odd = i[1];
      cfg.stop_bit_count_sel = i[1];
      bit_len = lens[i];
      chk_bit("tx_buffer_full_flag_free", 1'b0, status_live.tx_buffer_full_flag);
      tx_wr(8'ha5 ^ 8'(i));
      chk_bit("tx_buffer_full_flag_set", 1'b1, status_live.tx_buffer_full_flag);
      wait_tx_irq(got);
      chk_bit("tx_irq", 1'b1, got);
      chk_bit("tx_buffer_full_flag_clr", 1'b0, status_live.tx_buffer_full_flag);
      expect_frame(8'ha5 ^ 8'(i));
      rx_frame(8'h3c + 8'(i), 1'b0, 1'b0, 1);
      chk_val("rx_flags", 10'h1, {5'h0, status_live[4:0]});
      pulse_status();
      rx_rd(v);
      chk_val("rx_data", {2'b00, 8'h3c + 8'(i)}, {2'b00, v});
      chk_bit("rx_buffer_full_flag_clr", 1'b0, status_live.rx_buffer_full_flag);
    end
    $display("test frame formats done");
    cfg = '0;
    cfg.tx_enable = 1'b1;
    cfg.receive_enable_bit = 1'b1;
    bit_len = 16;
    pwr.low_power_sleep_mode = 1'b1;
    tx_wr(8'h11);
    tx_wr(8'h22);
    repeat (100) @(negedge sys_clk);
    chk_bit("sleep_pin", 1'b1, serial_out_pin);
    pwr = '0;
    expect_frame(8'h22);
    chk_val("extra_frames", 10'h0, 10'(uts_serial_peer_i.rx_q.size()));
    $display("test overwrite done");
    cfg.tx_enable = 1'b0;
    tx_in_valid = 1'b1;
    for (n = 0; n < 20 && tx_in_ready === 1'b1; n++) begin
      tx_in_data = 8'h40 + 8'(n);
      @(negedge sys_clk);
    end
    tx_in_valid = 1'b0;
    chk_val("fifo_fill", 10'(FIFO_DEPTH + 1), 10'(n));
    cfg.tx_enable = 1'b1;
    for (int k = 0; k < FIFO_DEPTH + 1; k++) expect_frame(8'h40 + 8'(k));
    chk_bit("fifo_drained", 1'b1, tx_in_ready);
    $display("test queue done");
    cfg.parity_enable = 1'b1;
    pulse_status();
    rx_frame(8'h5a, 1'b1, 1'b0, 1);
    chk_bit("perr_set", 1'b1, status_live.parity_err);
    rx_rd(v);
    chk_bit("perr_kept", 1'b1, status_live.parity_err);
    pulse_status();
    rx_rd(v);
    chk_bit("perr_clr", 1'b0, status_live.parity_err);
    rx_frame(8'h77, 1'b0, 1'b1, 1);
    chk_bit("ferr_set", 1'b1, status_live.framing_err);
    pulse_status();
    rx_rd(v);
    chk_bit("ferr_clr", 1'b0, status_live.framing_err);
    rx_frame(8'h81, 1'b0, 1'b0, 1);
    rx_frame(8'h82, 1'b1, 1'b1, 1);
    chk_val("ovr_flags", 10'h9, {5'h0, status_live[4:0]});
    chk_val("ovr_keep", 10'h81, {2'b00, receive_buffer});
    rx_frame(8'h83, 1'b1, 1'b0, 0);
    chk_val("ovr_quiet", 10'h9, {5'h0, status_live[4:0]});
    pulse_status();
    chk_val("status_rd", 10'h9, {4'h0, status_data});
    rx_rd(v);
    chk_val("ovr_clr", 10'h0, {5'h0, status_live[4:0]});
    $display("test receive errors done");
    test_done();
  end
endmodule
